/* genset_defines.svh */
`ifndef GENSET_DEFINES_SVH
`define GENSET_DEFINES_SVH
// -----------------------------------------------------------------------------
// register map (byte addresses)
// -----------------------------------------------------------------------------
`define REG_CTRL        6'h00
`define REG_STATUS      6'h04
`define REG_T_START     6'h08
`define REG_T_PREHEAT   6'h0c
`define REG_T_CRANK     6'h10
`define REG_T_IDLE      6'h14
`define REG_T_HEAT      6'h18
`define REG_T_GCONT     6'h1c
`define REG_T_MWAIT     6'h20
`define REG_T_MCONT     6'h24
`define REG_T_COOL      6'h28
`define REG_T_SOLE      6'h2c
`define REG_T_STOP      6'h30
`define REG_CRANKS      6'h34
`define REG_T_CRWAIT    6'h38
// ctrl fields
`define CTRL_MODE_REQ   0
`define CTRL_STOP_PRESS 1
`define CTRL_LOCK_EN    2
`define CTRL_RSTART_EN  3
`define CTRL_PHASE_EN   4
`define CTRL_SCHED_OFF  5
// -----------------------------------------------------------------------------
// tick and timing
// -----------------------------------------------------------------------------
`define TICK_DIV        20'h3_0d3f
`define TIMER_W         16
`define IDLE_LEAD       16'h0001
`define FLASH_BIT       4
`endif

/* genset_pkg.sv */
package genset_pkg;
    typedef enum logic [3:0] {
        ST_REST, ST_START_DLY, ST_PREHEAT, ST_CRANK, ST_CRANK_WAIT, ST_IDLE, ST_HEAT,
        ST_GCONT_DLY, ST_LOADED, ST_MAINS_WAIT, ST_MCONT_DLY, ST_COOL, ST_STOP_SOL
    } seq_e;

    typedef struct packed {
        logic mains_v_ok;
        logic mains_f_ok;
        logic mains_ph_ok;
        logic gen_v_ok;
        logic gen_f_ok;
        logic gen_ph_ok;
        logic engine_run;
        logic simulate_mains;
        logic force_start;
        logic remote_start;
        logic panel_lock;
    } sense_s;

    typedef struct packed {
        logic fuel;
        logic preheat;
        logic crank;
        logic idle;
        logic stop_sol;
        logic gen_cont;
        logic mains_cont;
        logic auto_led;
        logic mains_avail;
        logic fail_stop;
    } drive_s;

    typedef struct packed {
        logic [15:0] t_start;
        logic [15:0] t_preheat;
        logic [15:0] t_crank;
        logic [15:0] t_idle;
        logic [15:0] t_heat;
        logic [15:0] t_gcont;
        logic [15:0] t_mwait;
        logic [15:0] t_mcont;
        logic [15:0] t_cool;
        logic [15:0] t_sole;
        logic [15:0] t_stop;
        logic [15:0] t_crwait;
        logic [3:0]  cranks;
    } timers_s;

    typedef struct packed {
        seq_e        st;
        logic        auto_mode;
        logic        mode_req_d;
        logic        stop_d;
        logic        lock_en;
        logic        rstart_en;
        logic        phase_en;
        logic        sched_off;
        logic        stopping;
        logic [15:0] stop_cnt;
        logic [15:0] tmr;
        logic [3:0]  tries;
        logic [19:0] div;
        logic        tick;
        logic [7:0]  flash;
        logic [10:0] s1;
        logic [10:0] s2;
        logic [10:0] s3;
        logic [10:0] sf;
        drive_s      drv;
        timers_s     tm;
        logic        waitreq;
        logic [31:0] rdata;
    } state_s;
endpackage

/* genset_mode_sequencer.sv */
`timescale 1ns/1ps
`include "genset_defines.svh"
module genset_mode_sequencer
    import genset_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // sensed inputs from pins
    input  wire sense_s      sense,
    // engine and contactor drive
    output drive_s           drive
);
    state_s q;
    state_s d;
    sense_s sn;
    logic   mains_ok;
    logic   gen_ok;
    logic   tmr_done;
    logic   acc;
    logic   wr;

    // ---------------------------------------------------------------
    // combinational next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        // pin filter: three flops; a bit moves only once the second and third agree
        sn = sense_s'((q.s3 & ~(q.s2 ^ q.s3)) | (q.sf & (q.s2 ^ q.s3)));
        d.s1 = sense;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.sf = sn; // last agreed value, held while the stages differ
        // common tick divider
        d.tick = 1'b0;
        d.div = q.div + 20'h0_0001;
        if (q.div == `TICK_DIV) begin
            d.div = '0;
            d.tick = 1'b1;
            d.flash = q.flash + 8'h01;
        end
        // mains evaluation order
        mains_ok = sn.mains_v_ok & sn.mains_f_ok & (sn.mains_ph_ok | ~q.phase_en);
        if (sn.simulate_mains) mains_ok = 1'b1;
        if (sn.force_start) mains_ok = 1'b0;
        if (q.rstart_en) mains_ok = ~sn.remote_start;
        gen_ok = sn.gen_v_ok & sn.gen_f_ok & sn.gen_ph_ok;
        d.drv.mains_avail = mains_ok;
        tmr_done = q.tmr == '0;
        if (q.tick && !tmr_done) d.tmr = q.tmr - 16'h0001;
        // bus access
        acc = (avs_read | avs_write) & q.waitreq;
        wr = avs_write & q.waitreq;
        d.waitreq = ~(avs_read | avs_write) | ~q.waitreq;
        if (!(avs_read | avs_write)) d.waitreq = 1'b1;
        d.rdata = '0;
        if (wr) begin
            case (avs_address)
                `REG_CTRL: begin
                    if (!(q.lock_en && sn.panel_lock)) begin
                        d.auto_mode = avs_writedata[`CTRL_MODE_REQ];
                    end
                    d.lock_en = avs_writedata[`CTRL_LOCK_EN];
                    d.rstart_en = avs_writedata[`CTRL_RSTART_EN];
                    d.phase_en = avs_writedata[`CTRL_PHASE_EN];
                    d.sched_off = avs_writedata[`CTRL_SCHED_OFF];
                    d.stop_d = avs_writedata[`CTRL_STOP_PRESS];
                end
                `REG_T_START:   d.tm.t_start = avs_writedata[15:0];
                `REG_T_PREHEAT: d.tm.t_preheat = avs_writedata[15:0];
                `REG_T_CRANK:   d.tm.t_crank = avs_writedata[15:0];
                `REG_T_IDLE:    d.tm.t_idle = avs_writedata[15:0];
                `REG_T_HEAT:    d.tm.t_heat = avs_writedata[15:0];
                `REG_T_GCONT:   d.tm.t_gcont = avs_writedata[15:0];
                `REG_T_MWAIT:   d.tm.t_mwait = avs_writedata[15:0];
                `REG_T_MCONT:   d.tm.t_mcont = avs_writedata[15:0];
                `REG_T_COOL:    d.tm.t_cool = avs_writedata[15:0];
                `REG_T_SOLE:    d.tm.t_sole = avs_writedata[15:0];
                `REG_T_STOP:    d.tm.t_stop = avs_writedata[15:0];
                `REG_CRANKS:    d.tm.cranks = avs_writedata[3:0];
                `REG_T_CRWAIT:  d.tm.t_crwait = avs_writedata[15:0];
                default: ;
            endcase
        end
        if (acc && avs_read) begin
            case (avs_address)
                `REG_CTRL:      d.rdata = {26'h0, q.sched_off, q.phase_en, q.rstart_en, q.lock_en, 1'b0, q.auto_mode};
                `REG_STATUS:    d.rdata = {18'h0, q.st, 2'h0, q.drv.fail_stop, q.drv.mains_avail, q.drv.gen_cont,
                                           q.drv.mains_cont, q.drv.crank, q.drv.fuel, q.drv.stop_sol, q.drv.idle};
                `REG_T_START:   d.rdata = {16'h0, q.tm.t_start};
                `REG_T_PREHEAT: d.rdata = {16'h0, q.tm.t_preheat};
                `REG_T_CRANK:   d.rdata = {16'h0, q.tm.t_crank};
                `REG_T_IDLE:    d.rdata = {16'h0, q.tm.t_idle};
                `REG_T_HEAT:    d.rdata = {16'h0, q.tm.t_heat};
                `REG_T_GCONT:   d.rdata = {16'h0, q.tm.t_gcont};
                `REG_T_MWAIT:   d.rdata = {16'h0, q.tm.t_mwait};
                `REG_T_MCONT:   d.rdata = {16'h0, q.tm.t_mcont};
                `REG_T_COOL:    d.rdata = {16'h0, q.tm.t_cool};
                `REG_T_SOLE:    d.rdata = {16'h0, q.tm.t_sole};
                `REG_T_STOP:    d.rdata = {16'h0, q.tm.t_stop};
                `REG_CRANKS:    d.rdata = {28'h0, q.tm.cranks};
                `REG_T_CRWAIT:  d.rdata = {16'h0, q.tm.t_crwait};
                default:        d.rdata = '0;
            endcase
        end
        // stop timer supervision after the stop solenoid is energized at cooldown end
        if (q.stopping && q.tick && q.stop_cnt != '0) d.stop_cnt = q.stop_cnt - 16'h0001;
        if (q.stopping && q.stop_cnt == '0) d.stopping = 1'b0;
        // sequencer
        case (q.st)
            ST_REST: begin
                d.drv.mains_cont = mains_ok;
                if (q.auto_mode && !q.sched_off && !mains_ok) begin
                    d.st = ST_START_DLY;
                    d.tmr = q.tm.t_start;
                end
            end
            ST_START_DLY: begin
                if (mains_ok) d.st = ST_REST;
                else if (tmr_done) begin
                    d.st = ST_PREHEAT;
                    d.tmr = q.tm.t_preheat;
                    d.drv.fuel = 1'b1;
                    d.drv.preheat = 1'b1;
                    d.drv.fail_stop = 1'b0;
                end
            end
            ST_PREHEAT: if (tmr_done) begin
                d.st = ST_CRANK;
                d.tmr = q.tm.t_crank;
                d.tries = q.tm.cranks;
                d.drv.preheat = 1'b0;
                d.drv.crank = 1'b1;
            end
            ST_CRANK: begin
                if (sn.engine_run) begin
                    d.drv.crank = 1'b0;
                    d.drv.idle = 1'b1;
                    d.st = ST_IDLE;
                    d.tmr = q.tm.t_idle;
                end else if (tmr_done) begin
                    d.drv.crank = 1'b0;
                    d.tries = q.tries - 4'h1;
                    d.st = ST_CRANK_WAIT;
                    d.tmr = q.tm.t_crwait;
                end
            end
            ST_CRANK_WAIT: if (tmr_done) begin
                if (q.tries == 4'h0) begin
                    d.drv.fuel = 1'b0; // attempts exhausted
                    d.st = ST_REST;
                end else begin
                    d.st = ST_CRANK;
                    d.tmr = q.tm.t_crank;
                    d.drv.crank = 1'b1;
                end
            end
            ST_IDLE: if (tmr_done) begin
                d.drv.idle = 1'b0;
                d.st = ST_HEAT;
                d.tmr = q.tm.t_heat;
            end
            ST_HEAT: if (tmr_done && gen_ok) begin
                d.drv.mains_cont = 1'b0;
                d.st = ST_GCONT_DLY;
                d.tmr = q.tm.t_gcont;
            end
            ST_GCONT_DLY: if (tmr_done) begin
                d.drv.gen_cont = 1'b1;
                d.st = ST_LOADED;
            end
            ST_LOADED: if (mains_ok) begin
                d.st = ST_MAINS_WAIT;
                d.tmr = q.tm.t_mwait;
            end
            ST_MAINS_WAIT: begin
                if (!mains_ok) d.st = ST_LOADED;
                else if (tmr_done) begin
                    d.drv.gen_cont = 1'b0;
                    d.st = ST_MCONT_DLY;
                    d.tmr = q.tm.t_mcont;
                end
            end
            ST_MCONT_DLY: if (tmr_done) begin
                d.drv.mains_cont = 1'b1;
                d.st = ST_COOL;
                d.tmr = q.tm.t_cool;
            end
            ST_COOL: begin
                if (q.tmr <= `IDLE_LEAD) d.drv.idle = 1'b1;
                if (tmr_done) begin
                    d.drv.fuel = 1'b0;
                    d.drv.idle = 1'b0;
                    d.drv.stop_sol = 1'b1;
                    d.st = ST_STOP_SOL;
                    d.tmr = q.tm.t_sole;
                    d.stopping = 1'b1;
                    d.stop_cnt = q.tm.t_stop;
                end
            end
            ST_STOP_SOL: if (tmr_done) begin
                d.drv.stop_sol = 1'b0;
                d.st = ST_REST;
            end
            default: d.st = ST_REST;
        endcase
        // warning set after the sequencer so that it wins over the clear at a new start
        if (q.stopping && q.stop_cnt == '0 && sn.engine_run) d.drv.fail_stop = 1'b1;
        // leaving auto or schedule off: unload and cool down, or from start delay or preheat cut fuel and return to rest
        if ((!q.auto_mode || q.sched_off) && q.st != ST_REST && q.st != ST_COOL && q.st != ST_STOP_SOL) begin
            d.drv.gen_cont = 1'b0;
            d.drv.crank = 1'b0;
            d.drv.preheat = 1'b0;
            d.drv.mains_cont = mains_ok;
            if (q.st == ST_START_DLY || q.st == ST_PREHEAT) begin
                d.drv.fuel = 1'b0;
                d.st = ST_REST;
            end else begin
                d.st = ST_COOL;
                d.tmr = q.tm.t_cool;
            end
        end
        if (!q.auto_mode && q.st == ST_COOL) d.drv.mains_cont = mains_ok;
        // second stop press during cooldown
        if (wr && avs_address == `REG_CTRL && avs_writedata[`CTRL_STOP_PRESS] && !q.auto_mode
            && q.st == ST_COOL) begin
            d.tmr = '0;
        end
        d.drv.auto_led = q.auto_mode & ~(q.sched_off & q.flash[`FLASH_BIT]);
        if (sys_rst) d = '0;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        q <= d;
    end

    // outputs straight from flops
    assign drive = q.drv;
    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.waitreq;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    crank_cut_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_CRANK && sn.engine_run) |=> !q.drv.crank)
        else $error("crank not cut on firing");
    start_abort_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_START_DLY && mains_ok && q.auto_mode && !q.sched_off) |=> q.st == ST_REST)
        else $error("start not abandoned");
    stop_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_REST && !q.auto_mode) |=> q.st == ST_REST)
        else $error("start in stop mode");
    rest_mains_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_REST && $past(q.st) == ST_REST && !$past(sys_rst)) |=> q.drv.mains_cont == $past(mains_ok))
        else $error("mains contactor wrong");
    no_overlap_a: assert property (@(posedge clk) disable iff (sys_rst)
        !(q.drv.gen_cont && q.drv.mains_cont))
        else $error("both contactors closed");
    gen_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_HEAT && !gen_ok) |=> q.st != ST_GCONT_DLY)
        else $error("contactor without good alternator");
    simulate_ovr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (sn.simulate_mains && !sn.force_start && !q.rstart_en) |-> mains_ok)
        else $error("simulate mains ignored");
    force_ovr_a: assert property (@(posedge clk) disable iff (sys_rst)
        (sn.force_start && !q.rstart_en) |-> !mains_ok)
        else $error("forced start ignored");
    unload_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!q.auto_mode && q.drv.gen_cont) |=> !q.drv.gen_cont)
        else $error("load kept in stop mode");
    lock_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.lock_en && sn.panel_lock) |=> q.auto_mode == $past(q.auto_mode))
        else $error("mode changed under lock");
    idle_lead_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_COOL && !tmr_done && q.tmr <= `IDLE_LEAD) |=> q.drv.idle)
        else $error("no idle speed before cooldown end");
    cool_end_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_COOL && tmr_done) |=> (!q.drv.fuel && q.drv.stop_sol))
        else $error("fuel kept or no stop solenoid");
    second_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_COOL && !q.auto_mode && wr && avs_address == `REG_CTRL
         && avs_writedata[`CTRL_STOP_PRESS]) |=> ##1 !q.drv.fuel)
        else $error("second stop press ignored");
    fail_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.stopping && q.stop_cnt == '0 && sn.engine_run) |=> q.drv.fail_stop)
        else $error("fail to stop warning missing");
    preheat_on_a: assert property (@(posedge clk) disable iff (sys_rst)
        (q.st == ST_START_DLY && tmr_done && !mains_ok && q.auto_mode && !q.sched_off)
        |=> (q.drv.fuel && q.drv.preheat))
        else $error("fuel or preheat missing after start delay");
endmodule

/* engine_model.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// engine model: fires under crank and fuel, stops when fuel is cut unless hang is set
// -----------------------------------------------------------------------------
module engine_model
    import genset_pkg::*;
(
    // clock
    input  wire logic   clk,
    // sequencer outputs and bench controls
    input  wire drive_s drive,
    input  wire logic   slow,
    input  wire logic   hang,
    // engine state back to the sensing pins
    output logic        engine_run
);
    int fire_cnt = 0;

    initial engine_run = 1'b0;

    // prompt or slow firing; a hung engine keeps running without fuel
    always @(posedge clk) begin
        if (drive.crank && drive.fuel && !engine_run) begin
            fire_cnt <= fire_cnt + 1;
            if (fire_cnt >= (slow ? 40 : 3)) begin
                engine_run <= 1'b1;
            end
        end else begin
            fire_cnt <= 0;
        end
        if (engine_run && !drive.fuel && !hang) begin
            engine_run <= 1'b0;
        end
    end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "genset_defines.svh"
module tb_top
    import genset_pkg::*;
;
    localparam logic [9:0] F  = 10'h200;    // fuel
    localparam logic [9:0] PH = 10'h100;    // preheat
    localparam logic [9:0] CR = 10'h080;    // crank
    localparam logic [9:0] ID = 10'h040;    // idle speed
    localparam logic [9:0] SS = 10'h020;    // stop solenoid
    localparam logic [9:0] GC = 10'h010;    // genset contactor
    localparam logic [9:0] MC = 10'h008;    // mains contactor
    localparam logic [9:0] AL = 10'h004;    // auto indicator
    localparam logic [9:0] MA = 10'h002;    // mains available
    localparam logic [9:0] FS = 10'h001;    // fail to stop

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [5:0]  avs_address = '0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    sense_s      sense;
    drive_s      drive;
    logic [9:0]  dv;
    logic [6:0]  sb = '0;                   // mv mf mph sim force remote lock
    logic        slow = 1'b0;
    logic        hang = 1'b0;
    logic        engine_run;
    logic [31:0] seed = 32'h0000_4bff;
    logic [31:0] rd;
    int          failures = 0;
    int          check_count = 0;
    int          e;

    // clock and pin composition
    always #2.5 clk = ~clk;
    assign dv = drive;
    assign sense = {sb[6:4], {4{engine_run}}, sb[3:0]};

    genset_mode_sequencer uut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sense(sense), .drive(drive));
    engine_model eng (.clk(clk), .drive(drive), .slow(slow), .hang(hang), .engine_run(engine_run));

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic conclude();
        $display("counts: %0d checks, %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        failures++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            fail(msg);
        end
    endtask

    // avalon transfer: hold until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            fail("bus timeout");
            conclude();
        end
    endtask

    // wait a bounded time for masked outputs to reach a value
    task automatic await(input logic [9:0] m, input logic [9:0] v, input int lim, input string msg);
        int n;
        n = 0;
        while ((dv & m) !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check_count++;
        if ((dv & m) !== v) begin
            fail(msg);
            conclude();
        end
    endtask

    // masked outputs must keep a value for n cycles
    task automatic hold(input logic [9:0] m, input logic [9:0] v, input int n, input string msg);
        int bad;
        bad = 0;
        repeat (n) begin
            @(posedge clk);
            if ((dv & m) !== v) begin
                bad++;
            end
        end
        chk(32'(bad), 32'h0000_0000, msg);
    endtask

    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(dv), 32'h0000_0000, "outputs active after reset");
        bus(1'b1, `REG_CRANKS, 32'h0000_0003, rd);
        bus(1'b1, `REG_T_CRANK, 32'h0000_0001, rd);
        seed = lfsr(seed);
        bus(1'b1, `REG_T_CRWAIT, seed, rd);
        bus(1'b0, `REG_T_CRWAIT, 32'h0000_0000, rd);
        chk(rd, {16'h0000, seed[15:0]}, "timer readback");
        bus(1'b1, `REG_T_CRWAIT, 32'h0000_0000, rd);
        bus(1'b0, 6'h3c, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "unmapped read not zero");
        $display("test registers done");

        // mains evaluation model against random pins and overrides
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            bus(1'b1, `REG_CTRL, {28'h000_0000, seed[5], 3'h0}, rd);
            sb <= {seed[0], seed[1], 1'b1, seed[2], seed[3], seed[4], 1'b0};
            e = (seed[0] && seed[1]) ? 1 : 0;
            if (seed[2]) e = 1;
            if (seed[3]) e = 0;
            if (seed[5]) e = seed[4] ? 0 : 1;
            repeat (6) @(posedge clk);
            await(MA, (e == 1) ? MA : 10'h000, 20, "mains evaluation");
        end
        $display("test evaluation done");

        // stop mode mains contactor and ignored starts
        bus(1'b1, `REG_CTRL, 32'h0000_0000, rd);
        sb <= 7'b111_0000;
        await(MC, MC, 20, "mains contactor off with good mains");
        bus(1'b1, `REG_CTRL, 32'h0000_0010, rd);
        sb <= 7'b110_0000;
        repeat (6) @(posedge clk);
        await(MC, 10'h000, 20, "mains contactor on with bad phase order");
        bus(1'b1, `REG_CTRL, 32'h0000_0000, rd);
        sb <= 7'b000_0100;
        hold(F | CR, 10'h000, 100, "start in stop mode");
        $display("test stop mode done");

        // panel lock and schedule disable
        sb <= 7'b000_0001;
        bus(1'b1, `REG_CTRL, 32'h0000_0004, rd);
        bus(1'b1, `REG_CTRL, 32'h0000_0005, rd);
        hold(F, 10'h000, 100, "mode change under lock");
        bus(1'b0, `REG_CTRL, 32'h0000_0000, rd);
        chk({31'h0, rd[0]}, 32'h0000_0000, "mode bit taken under lock");
        sb <= 7'b000_0000;
        repeat (6) @(posedge clk);
        bus(1'b1, `REG_CTRL, 32'h0000_0021, rd);
        hold(F, 10'h000, 100, "start while schedule disabled");
        $display("test lock done");

        // auto start with a slow engine, then return of mains
        slow <= 1'b1;
        bus(1'b1, `REG_T_START, 32'h0000_0001, rd);
        bus(1'b1, `REG_CTRL, 32'h0000_0001, rd);
        await(AL, AL, 20, "auto indicator dark");
        hold(F, 10'h000, 30, "start before start delay");
        sb <= 7'b111_0000;
        await(MC, MC, 30, "start not abandoned on mains return");
        bus(1'b1, `REG_T_START, 32'h0000_0000, rd);
        sb <= 7'b000_0000;
        await(F, F, 200, "no fuel after start delay");
        chk(32'(dv & PH), 32'(PH), "no preheat with fuel");
        await(CR, CR, 50, "no cranking");
        await(GC | MC, GC, 500, "genset contactor not closed");
        chk(32'(dv & CR), 32'h0000_0000, "crank held after firing");
        sb <= 7'b111_0000;
        await(GC | MC, 10'h000, 50, "genset contactor not released first");
        await(MC, MC, 50, "mains contactor not closed");
        await(F | SS, SS, 100, "stop solenoid not energized");
        await(SS, 10'h000, 100, "stop solenoid stuck");
        $display("test auto cycle done");

        // stop mode while loaded with an engine that will not stop
        slow <= 1'b0;
        hang <= 1'b1;
        sb <= 7'b000_0000;
        await(GC, GC, 500, "no restart on mains loss");
        bus(1'b1, `REG_CTRL, 32'h0000_0000, rd);
        await(GC, 10'h000, 10, "load kept in stop mode");
        await(F, 10'h000, 100, "fuel kept in stop mode");
        await(FS, FS, 300, "no fail to stop warning");
        hang <= 1'b0;
        bus(1'b1, `REG_CTRL, 32'h0000_0001, rd);
        await(F | FS, F, 200, "warning not cleared at start");
        await(GC, GC, 500, "genset contactor not closed again");
        bus(1'b1, `REG_T_COOL, 32'h0000_0001, rd);
        bus(1'b1, `REG_CTRL, 32'h0000_0000, rd);
        await(GC | F | ID, F | ID, 20, "no unloaded idle cooldown");
        hold(F, F, 20, "cooldown cut short");
        bus(1'b1, `REG_CTRL, 32'h0000_0002, rd);
        await(F | GC, 10'h000, 50, "second stop press ignored");
        $display("test stop while running done");
        conclude();
    end
endmodule
